// ===== common/mcaa_consts.svh
// constants for the modem-control block of one serial channel: control bits, status layout, timing counts.
// assumes the includer compiles with mcaa_pkg and runs the channel clock at the rate below.
// How it works
// - while bit 8 of the line control word is set, each lead change is written into the receive character FIFO.
// - every lead change is always recorded in the status word, whatever bit 8 holds.
// - a ring change counts only after the new level has held for at least 30 ms; only then is it reported.
// - a change on carrier, set-ready, clear-to-send or ring raises the receive interrupt through the FIFO.
// - the block never gates a transmitter or receiver on any lead; software alone decides.
// - request-to-send and terminal-ready are driven out; clear-to-send, set-ready, carrier and ring come in.
`ifndef MCAA_CONSTS_SVH
`define MCAA_CONSTS_SVH

`define MCAA_LC_WIDTH          16
`define MCAA_LC_DTR_BIT        0
`define MCAA_LC_RTS_BIT        1
`define MCAA_LC_REPORT_BIT     8
`define MCAA_LC_RESET          16'h0000

`define MCAA_CLK_HZ            40000000
`define MCAA_RING_STABLE_MS    30
`define MCAA_RING_STABLE_CYC   ((`MCAA_CLK_HZ / 1000) * `MCAA_RING_STABLE_MS)

`define MCAA_LEADS_RESET       4'h0
`define MCAA_FIFO_TAG          1'h1

`endif

// ===== common/mcaa_pkg.sv
// types shared by the modem-control block and its ring filter.
// assumes nothing of its surroundings.
package mcaa_pkg;

	typedef struct packed {
		logic dcd;
		logic dsr;
		logic cts;
		logic ri;
	} mcaa_leads_type;

	typedef struct packed {
		mcaa_leads_type changed;
		mcaa_leads_type level;
	} mcaa_status_type;

	typedef struct packed {
		logic           modem_tag;
		logic [2:0]     spare;
		mcaa_leads_type changed;
		mcaa_leads_type level;
	} mcaa_fifo_word_type;

	typedef struct packed {
		logic filt;
		logic [31:0] cnt;
	} mcaa_filt_state_type;

endpackage

// ===== hdl/mcaa_ring_filter.sv
// stability filter for the ring lead: passes a new level only after it has held a set number of cycles.
// assumes its input is already synchronised to CLK_SYS.
`timescale 1ns/1ps
`include "mcaa_consts.svh"
module mcaa_ring_filter #(
	parameter int STABLE_CYCLES = `MCAA_RING_STABLE_CYC
) (
	input  wire logic clk_sys,
	input  wire logic arst_n,
	input  wire logic level_in,
	output logic      level_out
);

	if (STABLE_CYCLES < 2) begin : g_check
		$error("ring filter needs at least two stable cycles");
	end

	mcaa_pkg::mcaa_filt_state_type st_reg;
	mcaa_pkg::mcaa_filt_state_type st_next;

	// any bounce back to the held level restarts the count
	always_comb begin
		st_next = st_reg;
		if (level_in != st_reg.filt) begin
			if (st_reg.cnt >= 32'(STABLE_CYCLES - 1)) begin
				st_next.filt = level_in;
				st_next.cnt  = 32'h0000_0000;
			end else begin
				st_next.cnt = st_reg.cnt + 32'h0000_0001;
			end
		end else begin
			st_next.cnt = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign level_out = st_reg.filt;

	// helper: consecutive cycles the input has differed from the held level
	logic [31:0] run_reg;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			run_reg <= 32'h0000_0000;
		end else if (level_in != st_reg.filt) begin
			run_reg <= run_reg + 32'h0000_0001;
		end else begin
			run_reg <= 32'h0000_0000;
		end
	end

	a_filt_hold_time: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(st_reg.filt != $past(st_reg.filt)) |-> ($past(run_reg) >= 32'(STABLE_CYCLES - 1)))
		else $error("ring level passed before it was stable long enough");

	a_filt_no_bounce: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(level_in == st_reg.filt) |=> (st_reg.filt == $past(st_reg.filt)) && (st_reg.cnt == 32'h0000_0000))
		else $error("ring level moved while input matched it");

endmodule

// ===== hdl/mcaa_top.sv
// modem-control leads of one asynchronous serial channel: drives terminal-ready and request-to-send,
// watches ring, set-ready, clear-to-send and carrier, keeps a status word and offers FIFO entries.
// assumes one clock, the receive FIFO outside accepts a write on every pulse, and the line control
// word is held by the register logic outside this block.
`timescale 1ns/1ps
`include "mcaa_consts.svh"
module mcaa_top #(
	parameter int RING_STABLE_CYCLES = `MCAA_RING_STABLE_CYC
) (
	input  wire logic                         CLK_SYS,
	input  wire logic                         ARST_N,
	input  wire logic [`MCAA_LC_WIDTH-1:0]    LINE_CONTROL,
	input  wire logic [3:0]                   STATUS_CLR,
	input  wire logic                         RING_IN,
	input  wire logic                         DSR_IN,
	input  wire logic                         CTS_IN,
	input  wire logic                         DCD_IN,
	output logic                              DTR_OUT,
	output logic                              RTS_OUT,
	output mcaa_pkg::mcaa_status_type         STATUS,
	output logic                              FIFO_WR_VALID,
	output mcaa_pkg::mcaa_fifo_word_type      FIFO_WR_DATA
);

	if (RING_STABLE_CYCLES < 2) begin : g_check
		$error("RING_STABLE_CYCLES must be at least 2");
	end

	// the report enable must sit inside the control word
	if (`MCAA_LC_WIDTH <= `MCAA_LC_REPORT_BIT) begin : g_lc_check
		$error("line control word too narrow for the report enable");
	end

	typedef struct packed {
		mcaa_pkg::mcaa_leads_type     sync1;
		mcaa_pkg::mcaa_leads_type     sync2;
		mcaa_pkg::mcaa_leads_type     reported;
		mcaa_pkg::mcaa_leads_type     changed;
		logic                         dtr;
		logic                         rts;
		logic                         fifo_valid;
		mcaa_pkg::mcaa_fifo_word_type fifo_word;
	} mcaa_state_type;

	mcaa_state_type           state_reg;
	mcaa_state_type           state_next;
	logic                     ring_filtered;
	mcaa_pkg::mcaa_leads_type current;
	mcaa_pkg::mcaa_leads_type diff;

	// ring is slow and bouncy, so only it gets the long filter
	mcaa_ring_filter #(
		.STABLE_CYCLES (RING_STABLE_CYCLES)
	) u_ring_filter (
		.clk_sys   (CLK_SYS),
		.arst_n    (ARST_N),
		.level_in  (state_reg.sync2.ri),
		.level_out (ring_filtered)
	);

	function automatic mcaa_pkg::mcaa_leads_type lead_pack(
		input logic dcd,
		input logic dsr,
		input logic cts,
		input logic ri
	);
		mcaa_pkg::mcaa_leads_type l;
		l.dcd = dcd;
		l.dsr = dsr;
		l.cts = cts;
		l.ri  = ri;
		return l;
	endfunction

	always_comb begin
		current = state_reg.sync2;
		current.ri = ring_filtered;
		diff = state_reg.reported ^ current;
	end

	always_comb begin
		state_next = state_reg;
		// first stage feeds only the second
		state_next.sync1 = lead_pack(DCD_IN, DSR_IN, CTS_IN, RING_IN);
		state_next.sync2 = state_reg.sync1;
		state_next.reported = current;
		// set wins over a clear arriving in the same cycle
		state_next.changed = (state_reg.changed & ~mcaa_pkg::mcaa_leads_type'(STATUS_CLR)) | diff;
		// leads only go out; nothing here stalls a data path
		state_next.dtr = LINE_CONTROL[`MCAA_LC_DTR_BIT];
		state_next.rts = LINE_CONTROL[`MCAA_LC_RTS_BIT];
		// the FIFO write is what raises the receive interrupt downstream
		state_next.fifo_valid = (|diff) && LINE_CONTROL[`MCAA_LC_REPORT_BIT];
		if (state_next.fifo_valid) begin
			state_next.fifo_word.modem_tag = `MCAA_FIFO_TAG;
			state_next.fifo_word.spare     = 3'h0;
			state_next.fifo_word.changed   = diff;
			state_next.fifo_word.level     = current;
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign DTR_OUT       = state_reg.dtr;
	assign RTS_OUT       = state_reg.rts;
	assign STATUS        = {state_reg.changed, state_reg.reported};
	assign FIFO_WR_VALID = state_reg.fifo_valid;
	assign FIFO_WR_DATA  = state_reg.fifo_word;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!ARST_N);

	sequence s_dsr_rise_held;
		$rose(DSR_IN) ##0 DSR_IN [*3];
	endsequence

	sequence s_dcd_fall_held;
		$fell(DCD_IN) ##0 !DCD_IN [*3];
	endsequence

	sequence s_dsr_fall_held;
		$fell(DSR_IN) ##0 !DSR_IN [*3];
	endsequence

	sequence s_cts_rise_held;
		$rose(CTS_IN) ##0 CTS_IN [*3];
	endsequence

	sequence s_cts_fall_held;
		$fell(CTS_IN) ##0 !CTS_IN [*3];
	endsequence

	sequence s_dcd_rise_held;
		$rose(DCD_IN) ##0 DCD_IN [*3];
	endsequence

	a_sync_dsr_rise: assert property (s_dsr_rise_held |=> STATUS.level.dsr)
		else $error("set-ready rise not seen three cycles later");

	a_sync_dcd_fall: assert property (s_dcd_fall_held |=> !STATUS.level.dcd)
		else $error("carrier fall not seen three cycles later");

	a_status_change_set: assert property ((STATUS.level != $past(STATUS.level))
		|-> ((STATUS.changed & (STATUS.level ^ $past(STATUS.level))) == (STATUS.level ^ $past(STATUS.level))))
		else $error("lead change not recorded in status");

	a_status_set_wins: assert property ((|(diff & mcaa_pkg::mcaa_leads_type'(STATUS_CLR)))
		|=> ((STATUS.changed & $past(diff)) == $past(diff)))
		else $error("clear beat a simultaneous change");

	a_fifo_on_change: assert property ((|diff) && LINE_CONTROL[`MCAA_LC_REPORT_BIT]
		|=> FIFO_WR_VALID && FIFO_WR_DATA.modem_tag && (FIFO_WR_DATA.changed == $past(diff)))
		else $error("lead change not written to FIFO while enabled");

	a_fifo_gated_off: assert property (!LINE_CONTROL[`MCAA_LC_REPORT_BIT] |=> !FIFO_WR_VALID)
		else $error("FIFO written with reporting disabled");

	a_fifo_only_change: assert property (FIFO_WR_VALID |-> (STATUS.level != $past(STATUS.level)))
		else $error("FIFO entry without a lead change");

	a_ring_report_filtered: assert property ((STATUS.level.ri != $past(STATUS.level.ri))
		|-> ($past(ring_filtered) == STATUS.level.ri))
		else $error("ring reported without passing the filter");

	a_lead_outputs: assert property ($past(ARST_N)
		|-> (DTR_OUT == $past(LINE_CONTROL[`MCAA_LC_DTR_BIT]))
		&& (RTS_OUT == $past(LINE_CONTROL[`MCAA_LC_RTS_BIT])))
		else $error("terminal-ready or request-to-send not following control");

	a_sync_dsr_fall: assert property (s_dsr_fall_held |=> !STATUS.level.dsr)
		else $error("set-ready fall not seen three cycles later");

	a_sync_cts_rise: assert property (s_cts_rise_held |=> STATUS.level.cts)
		else $error("clear-to-send rise not seen three cycles later");

	a_sync_cts_fall: assert property (s_cts_fall_held |=> !STATUS.level.cts)
		else $error("clear-to-send fall not seen three cycles later");

	a_sync_dcd_rise: assert property (s_dcd_rise_held |=> STATUS.level.dcd)
		else $error("carrier rise not seen three cycles later");

	a_level_only_change: assert property ((diff == 4'h0) |=> $stable(STATUS.level))
		else $error("reported level moved without a lead change");

	a_status_clear: assert property ((|(STATUS_CLR & ~diff))
		|=> ((STATUS.changed & $past(STATUS_CLR & ~diff)) == 4'h0))
		else $error("change flag survived its clear");

	a_status_sticky: assert property ((|(STATUS.changed & ~STATUS_CLR))
		|=> ((STATUS.changed & $past(STATUS.changed & ~STATUS_CLR)) == $past(STATUS.changed & ~STATUS_CLR)))
		else $error("change flag lost without a clear");

	a_fifo_word_match: assert property (FIFO_WR_VALID
		|-> (FIFO_WR_DATA.level == STATUS.level) && (FIFO_WR_DATA.spare == 3'h0)
		&& (FIFO_WR_DATA.changed == (STATUS.level ^ $past(STATUS.level))))
		else $error("FIFO entry does not match the reported change");

	a_fifo_word_hold: assert property (!FIFO_WR_VALID |-> $stable(FIFO_WR_DATA))
		else $error("FIFO data moved without a write");

	a_ring_waits_filter: assert property ((ring_filtered == STATUS.level.ri) |=> $stable(STATUS.level.ri))
		else $error("ring level moved before the filter passed it");

	// modem leads never steer the control outputs
	a_leads_ignored: assert property ($past(ARST_N) && $stable(LINE_CONTROL[`MCAA_LC_DTR_BIT])
		&& $stable(LINE_CONTROL[`MCAA_LC_RTS_BIT]) |=> $stable(DTR_OUT) && $stable(RTS_OUT))
		else $error("control outputs moved with the control word steady");

endmodule

// ===== bench/mcaa_modem.sv
// modem partner: rings, answers, then raises set-ready, clear-to-send and carrier in turn.
// assumes the bench holds call high for a whole call; tst_en lets the bench set the leads directly.
`timescale 1ns/1ps
module mcaa_modem (
	input  wire logic                     clk_sys,
	input  wire logic                     dtr,
	input  wire logic                     rts,
	input  wire logic                     call,
	input  wire logic [7:0]               delay,
	input  wire logic                     tst_en,
	input  wire mcaa_pkg::mcaa_leads_type tst_leads,
	output mcaa_pkg::mcaa_leads_type      leads
);
	mcaa_pkg::mcaa_leads_type line = 4'h0;
	int                       cnt  = 0;
	assign leads = tst_en ? tst_leads : line; // leads come from the modem, or from tst_leads while tst_en is high
	// hangs up at once when terminal-ready drops
	always @(negedge clk_sys) begin
		if (!(call && dtr)) begin
			line <= 4'h0;
			cnt  <= 0;
		end else begin
			cnt     <= cnt + 1;
			line.ri <= (cnt < 20);
			if (cnt == 20 + delay) line.dsr <= 1'h1; // answered
			if (line.dsr && rts && cnt == 30 + delay) line.cts <= 1'h1; // clear-to-send only with rts
			if (cnt == 40 + delay) line.dcd <= 1'h1; // far carrier heard
		end
	end
endmodule

// ===== bench/mcaa_top_tb.sv
// self-checking bench: control leads, lead change reports, ring filter and whole calls.
// assumes the ring filter is shortened to 8 cycles; checks at falling edges.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module mcaa_top_tb;
	localparam int RING = 8;
	logic                        clk = 1'h0;
	logic                        arst_n = 1'h0;
	logic [15:0]                 lc = 16'h0000;
	logic [3:0]                  clr = 4'h0;
	logic                        call = 1'h0;
	logic [7:0]                  delay = 8'h00;
	logic                        tst_en = 1'h1;
	mcaa_pkg::mcaa_leads_type    tl = 4'h0;
	mcaa_pkg::mcaa_leads_type    leads;
	logic                        dtr, rts, wv;
	mcaa_pkg::mcaa_status_type   st;
	mcaa_pkg::mcaa_fifo_word_type wd;
	int                          num_errors = 0;
	int                          n_checks = 0;
	int                          seed = 47;
	logic [3:0]                  old, nw;
	logic                        rep;
	mcaa_top #(.RING_STABLE_CYCLES(RING)) mcaa_top_i (.CLK_SYS(clk), .ARST_N(arst_n), .LINE_CONTROL(lc),
		.STATUS_CLR(clr), .RING_IN(leads.ri), .DSR_IN(leads.dsr), .CTS_IN(leads.cts), .DCD_IN(leads.dcd),
		.DTR_OUT(dtr), .RTS_OUT(rts), .STATUS(st), .FIFO_WR_VALID(wv), .FIFO_WR_DATA(wd));
	mcaa_modem mcaa_modem_i (.clk_sys(clk), .dtr(dtr), .rts(rts), .call(call), .delay(delay),
		.tst_en(tst_en), .tst_leads(tl), .leads(leads));
	initial forever #12.5 clk = ~clk;
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic clear_all();
		clr = 4'hF;
		cyc(1);
		clr = 4'h0;
	endtask
	task automatic test_done();
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		cyc(5000);
		num_errors++;
		test_done();
	end
	initial begin
		cyc(6);
		`CHK("dtr_rst", 1'h0, dtr)
		`CHK("st_rst", 8'h00, st)
		`CHK("wv_rst", 1'h0, wv)
		arst_n = 1'h1;
		for (int i = 0; i < 8; i++) begin
			lc = 16'($random(seed));
			cyc(1);
			`CHK("dtr", lc[0], dtr)
			`CHK("rts", lc[1], rts)
		end
		// random steps on dsr, cts and dcd; ring held low so no filter delay
		for (int i = 0; i < 24; i++) begin
			lc[8] = 1'($random(seed));
			clear_all();
			old = st.level;
			nw = {3'($random(seed)), 1'h0};
			if (i == 0) nw = 4'hE;
			rep = (nw != old) && lc[8];
			tl = nw;
			cyc(2);
			clr = {4{i[0]}}; // a clear on the reporting edge loses to the change
			cyc(1);
			clr = 4'h0;
			`CHK("level", nw, st.level)
			`CHK("changed", nw ^ old, st.changed)
			`CHK("fifo_v", rep, wv)
			if (rep) `CHK("fifo_d", {4'h8, nw ^ old, nw}, wd)
			cyc(1);
			`CHK("fifo_v_end", 1'h0, wv)
		end
		tl = 4'h0;
		lc[8] = 1'h1;
		cyc(4);
		clear_all();
		tl.ri = 1'h1;
		cyc(RING - 3);
		tl.ri = 1'h0;
		cyc(20);
		`CHK("ri_short", 2'h0, {st.level.ri, st.changed.ri})
		tl.ri = 1'h1;
		cyc(RING);
		`CHK("ri_early", 1'h0, st.level.ri)
		cyc(5);
		`CHK("ri_late", 2'h3, {st.level.ri, st.changed.ri})
		tl.ri = 1'h0;
		cyc(RING + 5);
		tst_en = 1'h0;
		for (int i = 0; i < 3; i++) begin
			delay = 8'($random(seed) & 8'h1F);
			lc = {7'h00, 1'h1, 6'h00, (i != 1), 1'h1};
			cyc(2);
			clear_all();
			call = 1'h1;
			cyc(90); // carrier wait, scaled far down
			`CHK("call_lvl", {2'h3, (i != 1), 1'h0}, st.level)
			`CHK("call_chg", {2'h3, (i != 1), 1'h1}, st.changed)
			if (i == 0) begin
				clear_all();
				tl = 4'h6; // carrier gone for a moment only
				tst_en = 1'h1;
				cyc(4);
				tst_en = 1'h0;
				cyc(4);
				`CHK("dcd_back", 8'h8E, st)
			end
			lc[0] = 1'h0;
			cyc(6);
			`CHK("hang_lvl", 4'h0, st.level)
			call = 1'h0;
			cyc(4);
		end
		test_done();
	end
endmodule
